// File: common/forced_io_pkg.sv
// Constants for the forced input/output override block.
// Assumes a single system clock and parameter writes arriving as register strobes.
`default_nettype none
package forced_io_pkg;
	localparam int NUM_IN = 9;
	localparam int NUM_OUT = 5;
	localparam int REG_W = 16;
	localparam int MODE_W = 2;
	localparam logic [MODE_W-1:0] MODE_NONE = 2'h0;
	localparam logic [MODE_W-1:0] MODE_IN = 2'h1;
	localparam logic [MODE_W-1:0] MODE_OUT = 2'h2;
	localparam logic [MODE_W-1:0] MODE_BOTH = 2'h3;
	localparam int MODE_IN_BIT = 0;
	localparam int MODE_OUT_BIT = 1;
	localparam logic [REG_W-1:0] MODE_RESET = 16'h0000;
	localparam logic [REG_W-1:0] FIN_RESET = 16'h0000;
	localparam logic [REG_W-1:0] FOUT_RESET = 16'h0000;
endpackage
`default_nettype wire

// File: src/forced_io_override.sv
// Override of the nine digital inputs and five digital outputs by software force words.
// Assumes terminal inputs are asynchronous pins; internal functions, polarity and writes are on I_CLK.
//
// Function
// - Two-bit mode: 0 none, 1 inputs, 2 outputs, 3 both; resets to 0.
// - Input forcing takes every input level from the forced word, ignoring terminals.
// - Physical and virtual inputs both come from the forced word under forcing.
// - Each forced input bit is a level: 1 high, 0 low.
// - Forced input word: nine bits, input 1 in bit 0.
// - Output forcing drives every output from the forced output word.
// - Forced output bit 1 means function valid, 0 invalid; output 1 in bit 0.
// - Forced output state becomes a pin level through that output's polarity.
// - Input monitor equals applied input levels; under forcing equals forced word.
// - Mode is not retained; after power-on it returns to disabled.
// - Writing 0 to the mode restores normal terminal operation on the second edge after the write strobe.
`default_nettype none
module forced_io_override #(
	parameter int NUM_IN = forced_io_pkg::NUM_IN,
	parameter int NUM_OUT = forced_io_pkg::NUM_OUT
) (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic i_mode_wr,
	input wire logic [forced_io_pkg::REG_W-1:0] i_mode_wdata,
	input wire logic i_fin_wr,
	input wire logic [forced_io_pkg::REG_W-1:0] i_fin_wdata,
	input wire logic i_fout_wr,
	input wire logic [forced_io_pkg::REG_W-1:0] i_fout_wdata,
	input wire logic [NUM_IN-1:0] i_terminal_in,
	input wire logic [NUM_IN-1:0] i_virtual_input,
	input wire logic [NUM_IN-1:0] i_virtual_sel,
	input wire logic [NUM_OUT-1:0] i_out_function,
	input wire logic [NUM_OUT-1:0] i_out_polarity_low,
	output logic [NUM_IN-1:0] o_applied_in,
	output logic [NUM_OUT-1:0] o_terminal_out,
	output logic [forced_io_pkg::REG_W-1:0] o_force_mode_select,
	output logic [forced_io_pkg::REG_W-1:0] o_forced_input_levels,
	output logic [forced_io_pkg::REG_W-1:0] o_forced_output_functions,
	output logic [forced_io_pkg::REG_W-1:0] o_input_level_monitor,
	output logic [forced_io_pkg::REG_W-1:0] o_output_level_monitor
);
	// ==========================================================
	// Reset release
	logic rst_meta_q;
	logic rst_sync_q;
	logic rst_b;
	always_ff @(posedge I_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_b = rst_sync_q;

	// ==========================================================
	// Terminal input synchroniser
	logic [NUM_IN-1:0] in_meta_q;
	logic [NUM_IN-1:0] in_sync_q;
	always_ff @(posedge I_CLK or negedge rst_b)
	begin
		if (!rst_b)
		begin
			in_meta_q <= '0;
			in_sync_q <= '0;
		end
		else
		begin
			in_meta_q <= i_terminal_in;
			in_sync_q <= in_meta_q;
		end
	end

	// ==========================================================
	// Parameter registers
	logic [forced_io_pkg::REG_W-1:0] mode_q;
	logic [forced_io_pkg::REG_W-1:0] mode_d;
	logic [forced_io_pkg::REG_W-1:0] fin_q;
	logic [forced_io_pkg::REG_W-1:0] fin_d;
	logic [forced_io_pkg::REG_W-1:0] fout_q;
	logic [forced_io_pkg::REG_W-1:0] fout_d;
	always_comb
	begin
		mode_d = mode_q;
		fin_d = fin_q;
		fout_d = fout_q;
		if (i_mode_wr)
			mode_d = {{(forced_io_pkg::REG_W-forced_io_pkg::MODE_W){1'b0}},
				i_mode_wdata[forced_io_pkg::MODE_W-1:0]};
		if (i_fin_wr)
			fin_d = {{(forced_io_pkg::REG_W-NUM_IN){1'b0}}, i_fin_wdata[NUM_IN-1:0]};
		if (i_fout_wr)
			fout_d = {{(forced_io_pkg::REG_W-NUM_OUT){1'b0}}, i_fout_wdata[NUM_OUT-1:0]};
	end
	always_ff @(posedge I_CLK or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_q <= forced_io_pkg::MODE_RESET;
			fin_q <= forced_io_pkg::FIN_RESET;
			fout_q <= forced_io_pkg::FOUT_RESET;
		end
		else
		begin
			mode_q <= mode_d;
			fin_q <= fin_d;
			fout_q <= fout_d;
		end
	end

	// ==========================================================
	// Override datapath
	// The register value is used directly so a write reaches the outputs on the second edge after the strobe, not the third.
	logic force_in;
	logic force_out;
	logic [NUM_IN-1:0] in_d;
	logic [NUM_OUT-1:0] out_d;
	logic [NUM_OUT-1:0] func_sel;
	assign force_in = mode_q[forced_io_pkg::MODE_IN_BIT];
	assign force_out = mode_q[forced_io_pkg::MODE_OUT_BIT];
	always_comb
	begin
		// Forced levels replace terminal and virtual inputs.
		if (force_in)
			in_d = fin_q[NUM_IN-1:0];
		else
			in_d = (in_sync_q & ~i_virtual_sel) | (i_virtual_input & i_virtual_sel);
		func_sel = force_out ? fout_q[NUM_OUT-1:0] : i_out_function;
		// Polarity converts valid state to pin level.
		out_d = func_sel ^ i_out_polarity_low;
	end
	always_ff @(posedge I_CLK or negedge rst_b)
	begin
		if (!rst_b)
		begin
			o_applied_in <= '0;
			o_terminal_out <= '0;
			o_force_mode_select <= forced_io_pkg::MODE_RESET;
			o_forced_input_levels <= forced_io_pkg::FIN_RESET;
			o_forced_output_functions <= forced_io_pkg::FOUT_RESET;
			o_input_level_monitor <= '0;
			o_output_level_monitor <= '0;
		end
		else
		begin
			o_applied_in <= in_d;
			o_terminal_out <= out_d;
			o_force_mode_select <= mode_q;
			o_forced_input_levels <= fin_q;
			o_forced_output_functions <= fout_q;
			o_input_level_monitor <= {{(forced_io_pkg::REG_W-NUM_IN){1'b0}}, in_d};
			o_output_level_monitor <= {{(forced_io_pkg::REG_W-NUM_OUT){1'b0}}, out_d};
		end
	end

	// ==========================================================
	// Assertions
	property p_mode_reset;
		@(posedge I_CLK) $rose(rst_b) |-> mode_q == forced_io_pkg::MODE_RESET;
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("Mode not cleared at reset.");
	property p_mode_wr;
		@(posedge I_CLK) disable iff (!rst_b)
			i_mode_wr |=> mode_q[1:0] == $past(i_mode_wdata[1:0]);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("Mode write not taken next cycle.");
	property p_force_in;
		@(posedge I_CLK) disable iff (!rst_b)
			force_in |=> o_applied_in == $past(fin_q[NUM_IN-1:0]);
	endproperty
	a_force_in: assert property (p_force_in) else $error("Forced inputs not applied.");
	property p_normal_in;
		@(posedge I_CLK) disable iff (!rst_b)
			(!force_in && i_virtual_sel == '0) |=> o_applied_in == $past(in_sync_q);
	endproperty
	a_normal_in: assert property (p_normal_in) else $error("Terminal inputs not applied.");
	property p_virt_in;
		@(posedge I_CLK) disable iff (!rst_b)
			(force_in && i_virtual_sel != '0) |=> o_applied_in == $past(fin_q[NUM_IN-1:0]);
	endproperty
	a_virt_in: assert property (p_virt_in) else $error("Virtual inputs escaped forcing.");
	property p_in_mon;
		@(posedge I_CLK) disable iff (!rst_b)
			o_input_level_monitor[NUM_IN-1:0] == o_applied_in;
	endproperty
	a_in_mon: assert property (p_in_mon) else $error("Input monitor differs from inputs.");
	property p_force_out;
		@(posedge I_CLK) disable iff (!rst_b)
			force_out |=> o_terminal_out == ($past(fout_q[NUM_OUT-1:0]) ^ $past(i_out_polarity_low));
	endproperty
	a_force_out: assert property (p_force_out) else $error("Forced outputs wrong.");
	property p_polarity;
		@(posedge I_CLK) disable iff (!rst_b)
			(force_out && fout_q[0] && !i_out_polarity_low[0]) |=> o_terminal_out[0];
	endproperty
	a_polarity: assert property (p_polarity) else $error("High-active valid output not high.");
	property p_exit;
		@(posedge I_CLK) disable iff (!rst_b)
			(i_mode_wr && i_mode_wdata[1:0] == forced_io_pkg::MODE_NONE) |=> ##1
				o_terminal_out == ($past(i_out_function) ^ $past(i_out_polarity_low));
	endproperty
	a_exit: assert property (p_exit) else $error("Outputs not restored after exit.");
	c_force_in: cover property (@(posedge I_CLK) disable iff (!rst_b) mode_q[1:0] == forced_io_pkg::MODE_IN);
	c_force_out: cover property (@(posedge I_CLK) disable iff (!rst_b) mode_q[1:0] == forced_io_pkg::MODE_OUT);
	c_force_both: cover property (@(posedge I_CLK) disable iff (!rst_b) mode_q[1:0] == forced_io_pkg::MODE_BOTH);
	c_exit: cover property (@(posedge I_CLK) disable iff (!rst_b) force_in ##1 !force_in);
endmodule
`default_nettype wire

// File: verif/host_ctl_model.sv
// Host controller model: drives the terminal inputs and samples the terminal outputs.
// Assumes the bench names the wanted levels; the model launches them on the rising edge.
`default_nettype none
module host_ctl_model
(
	input wire logic i_clk,
	input wire logic [8:0] i_want,
	input wire logic [4:0] i_pins_out,
	output var logic [8:0] o_pins_in,
	output var logic [4:0] o_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Terminal side
	// One process drives the pins; the unknown level before the first edge only meets a synchroniser held in reset.
	always @(posedge i_clk)
	begin
		o_pins_in <= i_want;
		o_seen <= i_pins_out;
	end
endmodule
`default_nettype wire

// File: verif/forced_io_override_bench.sv
// Self-checking bench for the forced input/output override block.
// Assumes the host model on the terminals and write strobes driven by this bench.
`default_nettype none
module forced_io_override_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic mwr = 1'b0, fiwr = 1'b0, fowr = 1'b0;
	logic [15:0] mdat = 16'h0000, fidat = 16'h0000, fodat = 16'h0000;
	logic [8:0] want = 9'h000, virt = 9'h000, vsel = 9'h000, term, app;
	logic [4:0] func = 5'h00, pol = 5'h00, tout, seen;
	logic [15:0] rm, rfi, rfo, mi, mo;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	// ==========================================================
	// Expectations
	function automatic logic [8:0] exp_in(logic [15:0] m, fi, logic [8:0] t, v, s);
		return m[0] ? fi[8:0] : ((s & v) | (~s & t));
	endfunction
	function automatic logic [4:0] exp_out(logic [15:0] m, fo, logic [4:0] f, p);
		return (m[1] ? fo[4:0] : f) ^ p;
	endfunction
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (fail_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Clock, partner and design
	initial
	begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fail_count++;
			summarize();
		end
	end
	host_ctl_model host (.i_clk(clk), .i_want(want), .i_pins_out(tout), .o_pins_in(term), .o_seen(seen));
	forced_io_override dut (.I_CLK(clk), .I_RST_B(rst_b), .i_mode_wr(mwr), .i_mode_wdata(mdat),
		.i_fin_wr(fiwr), .i_fin_wdata(fidat), .i_fout_wr(fowr), .i_fout_wdata(fodat),
		.i_terminal_in(term), .i_virtual_input(virt), .i_virtual_sel(vsel), .i_out_function(func),
		.i_out_polarity_low(pol), .o_applied_in(app), .o_terminal_out(tout), .o_force_mode_select(rm),
		.o_forced_input_levels(rfi), .o_forced_output_functions(rfo), .o_input_level_monitor(mi),
		.o_output_level_monitor(mo));
	// ==========================================================
	// Main sequence
	// The first eight passes walk every mode with both polarity groups, then mode 0 after mode 3.
	initial
	begin
		void'($urandom(32'h1f4ad8f2));
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(rm, 16'h0000);
		for (int k = 0; k < 48; k++)
		begin
			@(posedge clk);
			want <= 9'($urandom);
			virt <= 9'($urandom);
			vsel <= 9'($urandom);
			func <= 5'($urandom);
			pol <= (k < 8) ? {5{k[2]}} : 5'($urandom);
			repeat (4) @(posedge clk);
			mdat <= (k < 8) ? 16'(k % 4) : 16'($urandom);
			fidat <= (k < 8) ? 16'h01FE : 16'($urandom);
			fodat <= (k < 8) ? 16'h001E : 16'($urandom);
			mwr <= 1'b1;
			fiwr <= 1'b1;
			fowr <= 1'b1;
			@(posedge clk);
			mwr <= 1'b0;
			fiwr <= 1'b0;
			fowr <= 1'b0;
			@(posedge clk);
			#1;
			chk(rm, {14'h0000, mdat[1:0]});
			chk(rfi, {7'h00, fidat[8:0]});
			chk(rfo, {11'h000, fodat[4:0]});
			chk({7'h00, app}, {7'h00, exp_in(mdat, fidat, term, virt, vsel)});
			chk(mi, {7'h00, exp_in(mdat, fidat, term, virt, vsel)});
			chk({11'h000, tout}, {11'h000, exp_out(mdat, fodat, func, pol)});
			chk(mo, {11'h000, exp_out(mdat, fodat, func, pol)});
			if (k == 3 || k == 7)
			begin
				chk(mi, 16'h01FE);
				chk(mo, k[2] ? 16'h0001 : 16'h001E);
			end
			@(posedge clk);
			#1;
			chk({11'h000, seen}, {11'h000, exp_out(mdat, fodat, func, pol)});
		end
		// A reset in mid-run must drop an active force mode.
		@(posedge clk);
		mdat <= 16'h0003;
		mwr <= 1'b1;
		@(posedge clk);
		mwr <= 1'b0;
		@(posedge clk);
		#1;
		chk(rm, 16'h0003);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(rm, 16'h0000);
		chk({11'h000, tout}, {11'h000, exp_out(16'h0000, 16'h0000, func, pol)});
		summarize();
	end
endmodule
`default_nettype wire
